// File: core/flash_cmd_defines.svh
`ifndef FLASH_CMD_DEFINES_SVH
`define FLASH_CMD_DEFINES_SVH

// ********************************************************************
// Instruction codes
// ********************************************************************
`define CMD_FAST_READ 8'h0b
`define CMD_FAST_READ_QUAD 8'heb
`define CMD_BURST_WRAP 8'h0c
`define CMD_DTR_BURST_WRAP 8'h0e
`define CMD_SET_READ_PARAM 8'hc0
`define CMD_SET_BURST_WRAP 8'h77
`define CMD_ENTER_FOUR_LINE 8'h38
`define CMD_EXIT_FOUR_LINE 8'hff
`define CMD_LOCK_ONE 8'h36
`define CMD_UNLOCK_ONE 8'h39
`define CMD_READ_LOCK 8'h3d
`define CMD_LOCK_ALL 8'h7e

// ********************************************************************
// Clock counts of each frame phase
// ********************************************************************
`define CODE_CLK_SERIAL 7'h08
`define CODE_CLK_QUAD 7'h02
`define ADDR_CLK_SERIAL 7'h18
`define ADDR_CLK_QUAD 7'h06
`define PARAM_CLK_QUAD 7'h02
`define WRAP_CLK_SERIAL 7'h08
`define FRAME_CNT_MAX 7'h7f

// ********************************************************************
// Field positions and reset values
// ********************************************************************
`define DUMMY_FIELD_MSB 5
`define DUMMY_FIELD_LSB 4
`define WRAP_FIELD_MSB 1
`define WRAP_FIELD_LSB 0
`define SERIAL_WRAP_MSB 5
`define SERIAL_WRAP_LSB 4
`define DUMMY_FIELD_RST 2'h0
`define WRAP_FIELD_RST 2'h0

// ********************************************************************
// Lock bit layout: 64 blocks, 16 sectors in the lowest and highest block
// ********************************************************************
`define LOCK_BITS 96
`define BLOCK_MSB 21
`define BLOCK_LSB 16
`define SECTOR_MSB 15
`define SECTOR_LSB 12
`define TOP_BLOCK 6'h3f
`define LOW_SECTOR_BASE 7'h40
`define HIGH_SECTOR_BASE 7'h50

`endif

// File: core/flash_cmd_pkg.sv
`default_nettype none

package flash_cmd_pkg;

  // Interface protocol mode
  typedef enum logic {
    MODE_SERIAL,
    MODE_FOUR_LINE
  } mode_type;

  // Volatile read parameters
  typedef struct packed {
    logic [1:0] dummy_count_field;
    logic [1:0] wrap_size_field;
  } read_param_type;

endpackage

`default_nettype wire

// File: core/quad_mode_readparam_block_lock.sv
`default_nettype none
`include "flash_cmd_defines.svh"

// Notes on behaviour
// - In four-line mode C0h parameter byte sets dummy count and wrap length.
// - In serial mode C0h is ignored; serial dummy counts stay fixed.
// - Serial wrap length comes from 77h bits; kept on entering four-line mode.
// - Reset defaults: wrap length 8 bytes, dummy count 2.
// - 0Ch reads like 0Bh but wraps inside the wrap-length block.
// - 0Eh wraps the same way using the programmed wrap length.
// - One mode at a time; only 38h enters four-line mode.
// - Power-up starts in serial mode.
// - 38h ignored unless quad enable bit is 1.
// - Entering four-line mode keeps write latch, suspend and wrap length.
// - FFh in four-line mode returns to serial; same state kept.
// - Lock bits protect only when write protect select is 1, else legacy bits.
// - Lock bits are volatile and all set after reset.
// - 36h plus 24-bit address sets that lock bit when select rises.
// - 39h plus 24-bit address clears that lock bit when select rises.
// - Lock, unlock and global lock need the write enable latch set.
// - 3Dh plus address returns a byte MSB first, LSB is lock state.
// - 7Eh alone sets every lock bit when select rises.
// - Software reset restores read parameters and wrap bits.
module quad_mode_readparam_block_lock (
  // System clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Serial link, clocked by the host
  input wire logic sclk_link,
  input wire logic cs_n,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe,
  // Array read port, link clock domain
  output logic [23:0] arr_addr,
  input wire logic [7:0] arr_data,
  // Status bits and reset request from the status logic
  input wire logic quad_enable_bit,
  input wire logic write_protect_select_bit,
  input wire logic write_enable_latch,
  input wire logic legacy_protect,
  input wire logic soft_reset,
  // Protection query from the program and erase engine
  input wire logic [23:0] prot_addr,
  output logic protect_hit,
  // Mode and read parameters
  output flash_cmd_pkg::mode_type four_line_command_mode,
  output flash_cmd_pkg::read_param_type read_param
);

  // ******************************************************************
  // Shared state and helpers
  // ******************************************************************
  logic [`LOCK_BITS-1:0] lock_r;
  logic link_rst;
  logic quad;
  logic first_r;
  logic [6:0] clk_cnt_r;
  logic [7:0] code_sr_r;
  logic [31:0] data_sr_r;
  logic [31:0] data_nxt;
  logic [2:0] out_cnt_r;
  logic [6:0] n_edges;
  logic [6:0] code_len;
  logic [6:0] addr_len;
  logic [6:0] post;
  logic [6:0] shift_cap;
  logic [6:0] data_start;
  logic [6:0] dummy_len;
  logic after_code;
  logic is_read;
  logic is_wrap;
  logic is_lock_rd;
  logic in_data;
  logic [23:0] wrap_mask;
  logic [7:0] out_byte;
  logic cs_n_s;
  logic cs_n_d_r;
  logic frame_end;
  logic [6:0] sys_code_len;

  // Lock bit index: sectors in the lowest and highest block, else blocks
  function automatic logic [6:0] lock_index(input logic [23:0] a);
    logic [5:0] blk;
    logic [3:0] sect_idx;
    blk = a[`BLOCK_MSB:`BLOCK_LSB];
    sect_idx = a[`SECTOR_MSB:`SECTOR_LSB];
    if (blk == 6'h00) begin
      lock_index = `LOW_SECTOR_BASE + {3'h0, sect_idx};
    end else if (blk == `TOP_BLOCK) begin
      lock_index = `HIGH_SECTOR_BASE + {3'h0, sect_idx};
    end else begin
      lock_index = {1'b0, blk};
    end
  endfunction

  // Dummy clocks from the field: 2, 4, 6 or 8
  function automatic logic [6:0] dummy_clocks(input logic [1:0] f);
    dummy_clocks = {4'h0, f, 1'b0} + 7'h02;
  endfunction

  // ******************************************************************
  // Link domain: frame capture on rising clock edges
  // ******************************************************************
  // Frame start flag and output lines clear while select is high; mode and parameters are
  // read as settled levels, they only change between frames
  assign link_rst = rst | cs_n;
  assign quad = (four_line_command_mode == flash_cmd_pkg::MODE_FOUR_LINE);
  assign code_len = quad ? `CODE_CLK_QUAD : `CODE_CLK_SERIAL;
  assign addr_len = quad ? `ADDR_CLK_QUAD : `ADDR_CLK_SERIAL;
  assign n_edges = first_r ? clk_cnt_r : 7'h00;
  assign after_code = (n_edges >= code_len);
  assign post = n_edges - code_len;
  assign shift_cap = (code_sr_r == `CMD_SET_BURST_WRAP) ? `WRAP_CLK_SERIAL : addr_len;
  assign is_wrap = quad && ((code_sr_r == `CMD_BURST_WRAP) ||
                            (code_sr_r == `CMD_DTR_BURST_WRAP));
  assign is_read = is_wrap || (quad && ((code_sr_r == `CMD_FAST_READ) ||
                                        (code_sr_r == `CMD_FAST_READ_QUAD)));
  assign is_lock_rd = (code_sr_r == `CMD_READ_LOCK);
  assign dummy_len = dummy_clocks(read_param.dummy_count_field);
  assign data_start = addr_len + (is_read ? dummy_len : 7'h00);
  assign in_data = after_code && (is_read || is_lock_rd) && (post >= data_start);
  assign wrap_mask = {17'h0, 7'h08 << read_param.wrap_size_field} - 24'h1;

  // Four bits per clock in four-line mode and for the 77h payload
  always_comb begin
    data_nxt = data_sr_r;
    if (after_code && (post < shift_cap)) begin
      if (quad || (code_sr_r == `CMD_SET_BURST_WRAP)) begin
        data_nxt = {data_sr_r[27:0], io_in};
      end else begin
        data_nxt = {data_sr_r[30:0], io_in[0]};
      end
    end
  end

  // Marks that the current frame has seen an edge
  always_ff @(posedge sclk_link or posedge link_rst) begin
    if (link_rst) begin
      first_r <= 1'b0;
    end else begin
      first_r <= 1'b1;
    end
  end

  // Edge count of the frame, held after select rises
  always_ff @(posedge sclk_link or posedge rst) begin
    if (rst) begin
      clk_cnt_r <= 7'h00;
    end else if (!first_r) begin
      clk_cnt_r <= 7'h01;
    end else if (clk_cnt_r != `FRAME_CNT_MAX) begin
      clk_cnt_r <= clk_cnt_r + 7'h01;
    end
  end

  // Instruction code and payload shift registers
  always_ff @(posedge sclk_link or posedge rst) begin
    if (rst) begin
      code_sr_r <= 8'h00;
      data_sr_r <= 32'h0;
    end else begin
      if (!after_code) begin
        code_sr_r <= quad ? {code_sr_r[3:0], io_in} : {code_sr_r[6:0], io_in[0]};
      end
      data_sr_r <= data_nxt;
    end
  end

  // Read address: loaded at the last address or dummy edge, stepped per output byte in four-line mode
  always_ff @(posedge sclk_link or posedge rst) begin
    if (rst) begin
      arr_addr <= 24'h0;
      out_cnt_r <= 3'h0;
    end else if (after_code && (post == data_start - 7'h01)) begin
      arr_addr <= data_nxt[23:0];
      out_cnt_r <= 3'h0;
    end else if (in_data) begin
      out_cnt_r <= out_cnt_r + 3'h1;
      if (quad && out_cnt_r[0]) begin
        if (is_wrap) begin
          arr_addr <= (arr_addr & ~wrap_mask) | ((arr_addr + 24'h1) & wrap_mask);
        end else begin
          arr_addr <= arr_addr + 24'h1;
        end
      end
    end
  end

  // ******************************************************************
  // Link domain: output on falling clock edges
  // ******************************************************************
  assign out_byte = is_lock_rd ? {7'h00, lock_r[lock_index(arr_addr)]} : arr_data;

  // High nibble or MSB first; lines released while select is high
  always_ff @(negedge sclk_link or posedge link_rst) begin
    if (link_rst) begin
      io_out <= 4'h0;
      io_oe <= 4'h0;
    end else if (in_data && quad) begin
      io_out <= out_cnt_r[0] ? out_byte[3:0] : out_byte[7:4];
      io_oe <= 4'hf;
    end else if (in_data) begin
      io_out <= {2'b00, out_byte[3'h7 - out_cnt_r], 1'b0};
      io_oe <= 4'h2;
    end else begin
      io_out <= 4'h0;
      io_oe <= 4'h0;
    end
  end

  // ******************************************************************
  // System domain: frame end detection
  // ******************************************************************
  sync2 #(
    .WIDTH(1),
    .RESET_VAL(1'b1)
  ) cs_sync (
    .clk(clk_sys),
    .rst(rst),
    .d(cs_n),
    .q(cs_n_s)
  );

  // Rising select edge; link registers are idle and settled by now
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cs_n_d_r <= 1'b1;
    end else begin
      cs_n_d_r <= cs_n_s;
    end
  end

  assign frame_end = cs_n_s & ~cs_n_d_r;
  assign sys_code_len = quad ? `CODE_CLK_QUAD : `CODE_CLK_SERIAL;

  // ******************************************************************
  // System domain: mode, parameters, lock bits, protection
  // ******************************************************************
  // Mode switch; no other state is touched here
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      four_line_command_mode <= flash_cmd_pkg::MODE_SERIAL;
    end else if (soft_reset) begin
      four_line_command_mode <= flash_cmd_pkg::MODE_SERIAL;
    end else if (frame_end && !quad && (code_sr_r == `CMD_ENTER_FOUR_LINE) &&
                 (clk_cnt_r == `CODE_CLK_SERIAL) && quad_enable_bit) begin
      four_line_command_mode <= flash_cmd_pkg::MODE_FOUR_LINE;
    end else if (frame_end && quad && (code_sr_r == `CMD_EXIT_FOUR_LINE) &&
                 (clk_cnt_r == `CODE_CLK_QUAD)) begin
      four_line_command_mode <= flash_cmd_pkg::MODE_SERIAL;
    end
  end

  // Read parameters: C0h only in four-line mode, 77h only in serial
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      read_param.dummy_count_field <= `DUMMY_FIELD_RST;
      read_param.wrap_size_field <= `WRAP_FIELD_RST;
    end else if (soft_reset) begin
      read_param.dummy_count_field <= `DUMMY_FIELD_RST;
      read_param.wrap_size_field <= `WRAP_FIELD_RST;
    end else if (frame_end && quad && (code_sr_r == `CMD_SET_READ_PARAM) &&
                 (clk_cnt_r == `CODE_CLK_QUAD + `PARAM_CLK_QUAD)) begin
      read_param.dummy_count_field <= data_sr_r[`DUMMY_FIELD_MSB:`DUMMY_FIELD_LSB];
      read_param.wrap_size_field <= data_sr_r[`WRAP_FIELD_MSB:`WRAP_FIELD_LSB];
    end else if (frame_end && !quad && (code_sr_r == `CMD_SET_BURST_WRAP) &&
                 (clk_cnt_r == `CODE_CLK_SERIAL + `WRAP_CLK_SERIAL)) begin
      read_param.wrap_size_field <= data_sr_r[`SERIAL_WRAP_MSB:`SERIAL_WRAP_LSB];
    end
  end

  // Lock bits: need the write latch and an exact frame length
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lock_r <= '1;
    end else if (soft_reset) begin
      lock_r <= '1;
    end else if (frame_end && write_enable_latch) begin
      if ((code_sr_r == `CMD_LOCK_ONE) && (clk_cnt_r == sys_code_len + addr_len)) begin
        lock_r[lock_index(data_sr_r[23:0])] <= 1'b1;
      end else if ((code_sr_r == `CMD_UNLOCK_ONE) &&
                   (clk_cnt_r == sys_code_len + addr_len)) begin
        lock_r[lock_index(data_sr_r[23:0])] <= 1'b0;
      end else if ((code_sr_r == `CMD_LOCK_ALL) && (clk_cnt_r == sys_code_len)) begin
        lock_r <= '1;
      end
    end
  end

  // Protection answer for the program and erase engine
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      protect_hit <= 1'b1;
    end else if (write_protect_select_bit) begin
      protect_hit <= lock_r[lock_index(prot_addr)];
    end else begin
      protect_hit <= legacy_protect;
    end
  end

endmodule

`default_nettype wire

// File: core/sync2.sv
`default_nettype none

// Two flip-flop level synchroniser
module sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Level in and out
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  // First stage feeds only the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= RESET_VAL;
      q <= RESET_VAL;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule

`default_nettype wire

// File: tb/flash_host_model.sv
`default_nettype none
// Host side of the link: select, clock and data lines
module flash_host_model (
  // Link outputs
  output var logic cs_n,
  output var logic sclk_link,
  output var logic [3:0] io_in,
  // Device answer
  input wire logic [3:0] io_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle link: select high, clock stopped low
  initial begin
    cs_n = 1'b1;
    sclk_link = 1'b0;
    io_in = 4'ha;
  end
  // One frame: a nibble per clock, then dummies, then answer clocks
  task automatic frame(input logic [3:0] tx[$], input int nd, input int nr,
                       output logic [3:0] rx[$]);
    logic [3:0] last;
    rx = {};
    last = 4'h5;
    // Offset keeps link edges clear of the system clock edges
    #1.3 cs_n = 1'b0;
    for (int c = 0; c < tx.size() + nd + nr; c++) begin
      last = (c < tx.size()) ? tx[c] : ~last;
      io_in = last;
      #32 sclk_link = 1'b1;
      if (c >= tx.size() + nd) rx.push_back(io_out);
      #32 sclk_link = 1'b0;
    end
    #16 cs_n = 1'b1;
    io_in = ~last;
    #38.7;
  endtask
endmodule
`default_nettype wire

// File: tb/mode_param_properties.sv
`default_nettype none
// ****
// Port checks of the mode, parameter and lock block
// ****
module mode_param_properties (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Observed ports
  input wire logic cs_n,
  input wire logic [3:0] io_oe,
  input wire logic quad_enable_bit,
  input wire logic write_protect_select_bit,
  input wire logic legacy_protect,
  input wire logic soft_reset,
  input wire logic protect_hit,
  input wire flash_cmd_pkg::mode_type four_line_command_mode,
  input wire flash_cmd_pkg::read_param_type read_param
);
  timeunit 1ns;
  timeprecision 1ps;
  logic q4;
  // Four-line mode flag
  assign q4 = four_line_command_mode == flash_cmd_pkg::MODE_FOUR_LINE;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  property p_rst_dflt;
    $fell(rst) |-> !q4 && read_param == 4'h0 && protect_hit;
  endproperty
  property p_oe_idle;
    cs_n [*2] |-> io_oe == 4'h0;
  endproperty
  property p_oe_shape;
    io_oe != 4'h0 |-> io_oe == (q4 ? 4'hf : 4'h2);
  endproperty
  property p_mode_settle;
    $changed(q4) |-> cs_n && $past(cs_n, 2);
  endproperty
  property p_par_settle;
    $changed(read_param) |-> cs_n && $past(cs_n, 2);
  endproperty
  property p_qe_gate;
    $rose(q4) |-> $past(quad_enable_bit);
  endproperty
  property p_dummy_q4;
    $changed(read_param.dummy_count_field) && !$past(soft_reset) |-> $past(q4);
  endproperty
  property p_soft;
    soft_reset |=> !q4 && read_param == 4'h0;
  endproperty
  property p_legacy;
    !$past(write_protect_select_bit) && !$past(rst) && !$past(soft_reset)
      |-> protect_hit == $past(legacy_protect);
  endproperty
  a_rst_dflt: assert property (p_rst_dflt) else $error("bad reset state");
  a_oe_idle: assert property (p_oe_idle) else $error("lines driven idle");
  a_oe_shape: assert property (p_oe_shape) else $error("bad line set");
  a_mode_settle: assert property (p_mode_settle) else $error("mode moved in frame");
  a_par_settle: assert property (p_par_settle) else $error("param moved in frame");
  a_qe_gate: assert property (p_qe_gate) else $error("entry without enable");
  a_dummy_q4: assert property (p_dummy_q4) else $error("dummy set in serial");
  a_soft: assert property (p_soft) else $error("soft reset ignored");
  a_legacy: assert property (p_legacy) else $error("legacy protect lost");
  c_enter: cover property ($rose(q4));
  c_dummy8: cover property (read_param.dummy_count_field == 2'h3);
  c_read: cover property (io_oe == 4'hf);
endmodule

bind quad_mode_readparam_block_lock mode_param_properties u_props (
  .clk_sys(clk_sys), .rst(rst), .cs_n(cs_n), .io_oe(io_oe),
  .quad_enable_bit(quad_enable_bit), .write_protect_select_bit(write_protect_select_bit),
  .legacy_protect(legacy_protect), .soft_reset(soft_reset), .protect_hit(protect_hit),
  .four_line_command_mode(four_line_command_mode), .read_param(read_param));
`default_nettype wire

// File: tb/quad_mode_readparam_block_lock_tb.sv
`default_nettype none
module quad_mode_readparam_block_lock_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic sclk_link, cs_n, protect_hit;
  logic [3:0] io_in, io_out, io_oe, tx[$], rx[$];
  logic [23:0] arr_addr, a;
  logic [23:0] prot_addr = 24'h0;
  logic [7:0] arr_data;
  logic quad_enable_bit = 1'b0;
  logic write_protect_select_bit = 1'b1;
  logic write_enable_latch = 1'b0;
  logic legacy_protect = 1'b0;
  logic soft_reset = 1'b0;
  logic [1:0] w;
  flash_cmd_pkg::mode_type mode;
  flash_cmd_pkg::read_param_type read_param;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  // Clock and array contents
  always #2 clk_sys = ~clk_sys;
  assign arr_data = mem(arr_addr);
  quad_mode_readparam_block_lock DUT (
    .clk_sys(clk_sys), .rst(rst), .sclk_link(sclk_link), .cs_n(cs_n),
    .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .arr_addr(arr_addr),
    .arr_data(arr_data), .quad_enable_bit(quad_enable_bit),
    .write_protect_select_bit(write_protect_select_bit),
    .write_enable_latch(write_enable_latch), .legacy_protect(legacy_protect),
    .soft_reset(soft_reset), .prot_addr(prot_addr), .protect_hit(protect_hit),
    .four_line_command_mode(mode), .read_param(read_param));
  flash_host_model HOST (.cs_n(cs_n), .sclk_link(sclk_link), .io_in(io_in), .io_out(io_out));
  // ****
  // Expectations and helpers
  // ****
  function automatic logic [7:0] mem(input logic [23:0] x);
    return x[7:0] ^ x[15:8] ^ 8'ha5;
  endfunction
  function automatic logic [23:0] at(input logic [23:0] x, input int j, input bit wr);
    logic [23:0] m;
    m = (24'h8 << w) - 24'h1;
    return wr ? ((x & ~m) | ((x + 24'(j)) & m)) : x + 24'(j);
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s at %0t: got %h want %h", what, $time, got, exp);
    end
  endtask
  task automatic put(input logic [7:0] v, input bit q);
    for (int i = 7; i >= 0; i -= (q ? 4 : 1))
      tx.push_back(q ? v[i -: 4] : {{3{~v[i]}}, v[i]});
  endtask
  task automatic cmd(input logic [7:0] c, input bit q, input bit ad);
    tx = {};
    put(c, q);
    if (ad) begin
      put(a[23:16], q);
      put(a[15:8], q);
      put(a[7:0], q);
    end
  endtask
  task automatic go(input int nd, input int nr);
    HOST.frame(tx, nd, nr, rx);
  endtask
  task automatic lock_is(input bit q, input logic exp);
    logic [7:0] b;
    b = 8'h0;
    cmd(8'h3d, q, 1);
    go(0, q ? 2 : 8);
    foreach (rx[i]) b = q ? {b[3:0], rx[i]} : {b[6:0], rx[i][1]};
    check(b, {7'h0, exp}, "lock byte");
  endtask
  task automatic hit_is(input logic exp);
    @(negedge clk_sys) prot_addr = a;
    repeat (3) @(negedge clk_sys);
    check({7'h0, protect_hit}, {7'h0, exp}, "protect");
  endtask
  task automatic burst(input logic [7:0] c, input logic [1:0] d);
    logic [23:0] s;
    int n;
    s = 24'($urandom) & 24'hfffffc;
    n = (8 << w) + 4;
    a = s;
    cmd(c, 1, 1);
    go(2 * d + 2, 2 * n);
    for (int j = 0; j < n; j++)
      check({rx[2*j], rx[2*j+1]}, mem(at(s, j, c == 8'h0c || c == 8'h0e)), "read byte");
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Cut a hang short
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 50000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  // ****
  // Main sequence
  // ****
  initial begin
    void'($urandom(7));
    repeat (20) @(negedge clk_sys);
    rst = 1'b0;
    repeat (3) @(negedge clk_sys);
    check(8'(mode), 8'h00, "mode");
    check(8'(read_param), 8'h00, "params");
    a = 24'($urandom);
    hit_is(1'b1);
    cmd(8'hc0, 0, 0);
    put(8'h33, 0);
    go(0, 0);
    check(8'(read_param), 8'h00, "params");
    w = 2'($urandom_range(3, 1));
    cmd(8'h77, 0, 0);
    repeat (3) put(8'h00, 1);
    put({2'b00, w, 4'h0}, 1);
    go(0, 0);
    check(8'(read_param), {6'h0, w}, "serial wrap");
    cmd(8'h38, 0, 0);
    go(0, 0);
    check(8'(mode), 8'h00, "mode");
    @(negedge clk_sys) quad_enable_bit = 1'b1;
    cmd(8'h38, 0, 0);
    go(0, 0);
    check(8'(mode), 8'h01, "mode");
    check(8'(read_param), {6'h0, w}, "wrap kept");
    for (int i = 0; i < 4; i++) begin
      w = 2'(i) ^ 2'h2;
      cmd(8'hc0, 1, 0);
      put({2'b00, 2'(i), 2'b00, w}, 1);
      go(0, 0);
      check(8'(read_param), {4'h0, 2'(i), w}, "params");
      burst(8'h0c, 2'(i));
      burst(8'h0e, 2'(i));
      burst(8'h0b, 2'(i));
      burst(8'heb, 2'(i));
    end
    a = {2'b00, 6'($urandom_range(62, 1)), 16'h0};
    lock_is(1, 1'b1);
    cmd(8'h39, 1, 1);
    go(0, 0);
    lock_is(1, 1'b1);
    @(negedge clk_sys) write_enable_latch = 1'b1;
    cmd(8'h39, 1, 1);
    go(0, 0);
    lock_is(1, 1'b0);
    hit_is(1'b0);
    @(negedge clk_sys) write_protect_select_bit = 1'b0;
    legacy_protect = 1'($urandom);
    hit_is(legacy_protect);
    @(negedge clk_sys) write_protect_select_bit = 1'b1;
    cmd(8'h36, 1, 1);
    go(0, 0);
    lock_is(1, 1'b1);
    a = 24'h003000;
    cmd(8'h39, 1, 1);
    go(0, 0);
    lock_is(1, 1'b0);
    a = 24'h004000;
    lock_is(1, 1'b1);
    cmd(8'h7e, 1, 0);
    go(0, 0);
    a = 24'h003000;
    lock_is(1, 1'b1);
    cmd(8'hff, 1, 0);
    go(0, 0);
    check(8'(mode), 8'h00, "mode");
    check(8'(read_param.wrap_size_field), 8'h01, "wrap kept");
    cmd(8'h39, 0, 1);
    go(0, 0);
    lock_is(0, 1'b0);
    @(negedge clk_sys) write_enable_latch = 1'b0;
    cmd(8'h7e, 0, 0);
    go(0, 0);
    lock_is(0, 1'b0);
    @(negedge clk_sys) soft_reset = 1'b1;
    @(negedge clk_sys) soft_reset = 1'b0;
    repeat (2) @(negedge clk_sys);
    check(8'(read_param), 8'h00, "params");
    lock_is(0, 1'b1);
    print_verdict();
  end
endmodule
`default_nettype wire
